/* File: logic/unicast_retry_cfg.svh */
// Constants for the unicast transmit retry and status control
`ifndef UNICAST_RETRY_CFG_SVH
`define UNICAST_RETRY_CFG_SVH
`define MODE_RST 2'h0
`define MODE_HDR_ACK 2'h0
`define MODE_PLAIN 2'h1
`define MODE_ACK_ONLY 2'h2
`define MODE_HDR_ONLY 2'h3
`define RETRY_RST 8'h00
`define MAC_RETRIES 2'h3
`define STAT_SUCCESS 8'h00
`define STAT_NO_ACK 8'h01
`define STAT_CCA_FAIL 8'h02
`define STAT_NET_ACK_FAIL 8'h21
`endif

/* File: logic/unicast_retry_pkg.sv */
// Types shared by the unicast transmit retry and status control
package unicast_retry_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SEND = 2'h1,
    ST_WAIT = 2'h3
  } state_t;

  typedef struct packed {
    logic header;
    logic macAck;
  } mode_flags_t;

  typedef struct packed {
    logic ackReq;
    logic appHeader;
    logic dupDetect;
    logic bcast;
    logic [7:0] frameId;
  } radio_req_t;

  typedef struct packed {
    logic ccaFail;
    logic macAck;
    logic e2eAck;
  } radio_res_t;

  typedef struct packed {
    logic [7:0] frameId;
    logic [7:0] code;
  } tx_status_t;
endpackage

/* File: logic/mode_decode.sv */
// Decode of the two-bit MAC mode setting into feature flags
`timescale 1ns/1ps
`include "unicast_retry_cfg.svh"
module mode_decode (
  // Mode in
  input wire logic [1:0] macModeSetting,
  // Flags out
  output unicast_retry_pkg::mode_flags_t flags
);
  always_comb begin
    flags.header = (macModeSetting == `MODE_HDR_ACK) ||
                   (macModeSetting == `MODE_HDR_ONLY);
    flags.macAck = (macModeSetting == `MODE_HDR_ACK) ||
                   (macModeSetting == `MODE_ACK_ONLY);
  end
endmodule // mode_decode

/* File: logic/unicast_retry_status_control.sv */
// Transmit retry sequencing and status reporting for unicast frames
//
// Summary of operation
// - Modes 0 and 3 add the vendor header and turn on duplicate detection.
// - Modes 1 and 2 send payload without the header, as plain pass through.
// - Modes 0 and 2 send unicast frames with the MAC ack request set.
// - With MAC ack on, a missing ack causes up to three retransmissions.
// - Modes 1 and 3 send unicast frames with no ack request.
// - Broadcast frames never carry the ack request.
// - After reset the mode setting is 0, header and MAC ack both on.
// - The retry count sets how many application retries follow the MAC ones.
// - Each application retry may again use up to three MAC retransmissions.
// - The retry count is ignored whenever the mode has no header.
// - Each request with a non-zero frame id gets exactly one status answer.
// - Without application retries and with ack on, report 00 or else 01, unless the channel is busy.
// - Without application retries and with ack off, report 00 unless the channel is busy.
// - Busy channel: three MAC retransmissions plus any application retries, then 02.
// - With application retries, report 00 on delivery or 21 when exhausted, unless the channel is busy.
`timescale 1ns/1ps
`include "unicast_retry_cfg.svh"
module unicast_retry_status_control #(
  parameter int RETRY_W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Configuration
  input wire logic cfgWrite,
  input wire logic [1:0] cfgMode,
  input wire logic [RETRY_W-1:0] cfgRetry,
  output logic [1:0] macModeSetting,
  output logic [RETRY_W-1:0] appRetryCount,
  // Host transmit request
  input wire logic txValid,
  input wire logic [7:0] txFrameId,
  input wire logic txBcast,
  output logic txReady,
  // Radio side
  output logic radioValid,
  output unicast_retry_pkg::radio_req_t radioReq,
  input wire logic radioDone,
  input wire unicast_retry_pkg::radio_res_t radioRes,
  // Host status
  output logic statusValid,
  output unicast_retry_pkg::tx_status_t statusOut
);
  generate
    if (RETRY_W < 1 || RETRY_W > 8) begin : g_bad_width
      $error("RETRY_W must lie between 1 and 8");
    end
  endgenerate

  typedef struct packed {
    unicast_retry_pkg::state_t state;
    logic [1:0] mode;
    logic [RETRY_W-1:0] retry;
    logic [RETRY_W-1:0] appTry;
    logic [1:0] macTry;
    logic appOn;
    unicast_retry_pkg::radio_req_t req;
    logic sendValid;
    logic statValid;
    unicast_retry_pkg::tx_status_t stat;
  } regs_t;

  regs_t st_r;
  regs_t st_nxt;
  unicast_retry_pkg::mode_flags_t flags;
  logic finish;
  logic macLeft;
  logic appLeft;
  logic macMiss;

  mode_decode u_mode_decode (
    .macModeSetting(st_r.mode),
    .flags(flags)
  );

  assign macLeft = (st_r.macTry != `MAC_RETRIES);
  // Less-than so a count lowered mid frame still ends the retries
  assign appLeft = st_r.appOn && (st_r.appTry < st_r.retry);
  assign macMiss = st_r.req.ackReq && !radioRes.macAck;
  assign finish = (st_r.state == unicast_retry_pkg::ST_WAIT) && radioDone;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sendValid = 1'b0;
    st_nxt.statValid = 1'b0;
    if (cfgWrite) begin
      st_nxt.mode = cfgMode;
      st_nxt.retry = cfgRetry;
    end
    case (st_r.state)
      unicast_retry_pkg::ST_IDLE: begin
        if (txValid) begin
          // Flags are frozen per frame so a mode change cannot tear it
          st_nxt.req.appHeader = flags.header;
          st_nxt.req.dupDetect = flags.header;
          st_nxt.req.ackReq = flags.macAck && !txBcast;
          st_nxt.req.bcast = txBcast;
          st_nxt.req.frameId = txFrameId;
          // Header off means the retry count has no effect
          st_nxt.appOn = flags.header && (st_r.retry != '0) &&
                         !txBcast;
          st_nxt.macTry = 2'h0;
          st_nxt.appTry = '0;
          st_nxt.state = unicast_retry_pkg::ST_SEND;
        end
      end
      unicast_retry_pkg::ST_SEND: begin
        st_nxt.sendValid = 1'b1;
        st_nxt.state = unicast_retry_pkg::ST_WAIT;
      end
      unicast_retry_pkg::ST_WAIT: begin
        if (radioDone) begin
          st_nxt.state = unicast_retry_pkg::ST_IDLE;
          st_nxt.stat.frameId = st_r.req.frameId;
          if (radioRes.ccaFail || macMiss) begin
            if (macLeft) begin
              st_nxt.macTry = st_r.macTry + 2'h1;
              st_nxt.state = unicast_retry_pkg::ST_SEND;
            end else if (appLeft) begin
              st_nxt.appTry = st_r.appTry + 1'b1;
              st_nxt.macTry = 2'h0;
              st_nxt.state = unicast_retry_pkg::ST_SEND;
            end else if (radioRes.ccaFail) begin
              st_nxt.stat.code = `STAT_CCA_FAIL;
            end else if (st_r.appOn) begin
              st_nxt.stat.code = `STAT_NET_ACK_FAIL;
            end else begin
              st_nxt.stat.code = `STAT_NO_ACK;
            end
          end else if (st_r.appOn && !radioRes.e2eAck) begin
            if (appLeft) begin
              st_nxt.appTry = st_r.appTry + 1'b1;
              st_nxt.macTry = 2'h0;
              st_nxt.state = unicast_retry_pkg::ST_SEND;
            end else begin
              st_nxt.stat.code = `STAT_NET_ACK_FAIL;
            end
          end else begin
            st_nxt.stat.code = `STAT_SUCCESS;
          end
          // Zero frame id asks for no answer
          st_nxt.statValid = (st_nxt.state == unicast_retry_pkg::ST_IDLE)
                             && (st_r.req.frameId != 8'h00);
        end
      end
      default: begin
        st_nxt.state = unicast_retry_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.mode <= `MODE_RST;
      st_r.retry <= RETRY_W'(`RETRY_RST);
    end else begin
      st_r <= st_nxt;
    end
  end

  assign txReady = (st_r.state == unicast_retry_pkg::ST_IDLE);
  assign macModeSetting = st_r.mode;
  assign appRetryCount = st_r.retry;
  assign radioValid = st_r.sendValid;
  assign radioReq = st_r.req;
  assign statusValid = st_r.statValid;
  assign statusOut = st_r.stat;

  chk_mode_hold: assert property (
    @(posedge clock) disable iff (!resetn)
    !cfgWrite |=> $stable(macModeSetting))
    else $error("mode changed without a write");

  chk_bcast_noack: assert property (
    @(posedge clock) disable iff (!resetn)
    radioValid && radioReq.bcast |-> !radioReq.ackReq)
    else $error("broadcast sent with ack request");

  chk_header_mode: assert property (
    @(posedge clock) disable iff (!resetn)
    txValid && txReady |-> ##2 radioValid &&
      radioReq.appHeader == $past(flags.header, 2) &&
      radioReq.dupDetect == radioReq.appHeader)
    else $error("header flag does not follow mode");

  chk_ack_mode: assert property (
    @(posedge clock) disable iff (!resetn)
    txValid && txReady |-> ##2
      radioReq.ackReq == $past(flags.macAck && !txBcast, 2))
    else $error("ack request does not follow mode");

  chk_status_id: assert property (
    @(posedge clock) disable iff (!resetn)
    finish && st_nxt.state == unicast_retry_pkg::ST_IDLE &&
      st_r.req.frameId != 8'h00 |=> statusValid ##1 !statusValid)
    else $error("status answer missing or repeated");

  chk_mac_retx: assert property (
    @(posedge clock) disable iff (!resetn)
    finish && !radioRes.ccaFail && macMiss && macLeft
      |=> !statusValid ##1 radioValid)
    else $error("missed retransmission");

  chk_cca_code: assert property (
    @(posedge clock) disable iff (!resetn)
    finish && radioRes.ccaFail && !macLeft && !appLeft &&
      st_r.req.frameId != 8'h00
      |=> statusValid && statusOut.code == `STAT_CCA_FAIL)
    else $error("busy channel code wrong");

  chk_noack_code: assert property (
    @(posedge clock) disable iff (!resetn)
    finish && !radioRes.ccaFail && macMiss && !macLeft && !st_r.appOn
      && st_r.req.frameId != 8'h00
      |=> statusValid && statusOut.code == `STAT_NO_ACK)
    else $error("no-ack code wrong");

  chk_plain_ok: assert property (
    @(posedge clock) disable iff (!resetn)
    finish && !radioRes.ccaFail && !st_r.req.ackReq && !st_r.appOn
      && st_r.req.frameId != 8'h00
      |=> statusValid && statusOut.code == `STAT_SUCCESS)
    else $error("unacked send not reported as success");

  chk_app_fail: assert property (
    @(posedge clock) disable iff (!resetn)
    finish && !radioRes.ccaFail && !macMiss && st_r.appOn &&
      !radioRes.e2eAck && !appLeft && st_r.req.frameId != 8'h00
      |=> statusValid && statusOut.code == `STAT_NET_ACK_FAIL)
    else $error("network ack failure code wrong");
endmodule // unicast_retry_status_control

/* File: tb/radio_node.sv */
// Remote radio node answering each transmit attempt
`timescale 1ns/1ps
module radio_node (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Scenario control
  input wire logic clear,
  input wire logic cca,
  input wire logic [7:0] lost,
  input wire logic [1:0] lat,
  // Radio side
  input wire logic radioValid,
  input wire unicast_retry_pkg::radio_req_t radioReq,
  output logic radioDone,
  output unicast_retry_pkg::radio_res_t radioRes
);
  logic [7:0] tryCount_r;
  logic [2:0] wait_r;
  logic [2:0] junk_r;
  unicast_retry_pkg::radio_res_t res_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tryCount_r <= 8'h00;
      wait_r <= 3'h0;
      junk_r <= 3'h0;
      res_r <= 3'h0;
    end else begin
      junk_r <= junk_r + 3'h1;
      if (clear)
        tryCount_r <= 8'h00;
      if (radioValid) begin
        // First lost attempts never arrive, later ones do
        res_r.ccaFail <= cca;
        res_r.macAck <= radioReq.ackReq && !cca &&
                        tryCount_r >= lost;
        res_r.e2eAck <= radioReq.appHeader && !cca && tryCount_r >= lost;
        tryCount_r <= tryCount_r + 8'h01;
        wait_r <= {1'b0, lat} + 3'h1;
      end else if (wait_r != 3'h0)
        wait_r <= wait_r - 3'h1;
    end
  end
  assign radioDone = wait_r == 3'h1;
  // Outside a result the lines carry a moving pattern
  assign radioRes = radioDone ? res_r :
                    unicast_retry_pkg::radio_res_t'(junk_r);
endmodule // radio_node

/* File: tb/unicast_retry_status_control_tb_top.sv */
// Self-checking bench for the unicast retry and status control
`timescale 1ns/1ps
module unicast_retry_status_control_tb_top;
  typedef struct {logic [11:0] req; logic [15:0] stat; int tries;} note_t;
  logic clock = 0, resetn = 0, cfgWrite = 0, txValid = 0, txBcast = 0;
  logic cca = 0, prevRdy = 1, txReady, radioValid, radioDone, statusValid;
  logic [1:0] cfgMode = 2'h0, lat = 2'h0, macModeSetting;
  logic [7:0] cfgRetry = 8'h00, appRetryCount, txFrameId = 8'h00;
  logic [7:0] lost = 8'h00;
  logic [31:0] seed = 32'h82e30887;
  unicast_retry_pkg::radio_req_t radioReq;
  unicast_retry_pkg::radio_res_t radioRes;
  unicast_retry_pkg::tx_status_t statusOut;
  note_t q[$];
  int nMismatch = 0, cmpCount = 0, tries = 0;
  always #10 clock = ~clock;
  unicast_retry_status_control dut_u (.clock(clock), .resetn(resetn),
    .cfgWrite(cfgWrite), .cfgMode(cfgMode), .cfgRetry(cfgRetry),
    .macModeSetting(macModeSetting), .appRetryCount(appRetryCount),
    .txValid(txValid), .txFrameId(txFrameId), .txBcast(txBcast),
    .txReady(txReady), .radioValid(radioValid), .radioReq(radioReq),
    .radioDone(radioDone), .radioRes(radioRes),
    .statusValid(statusValid), .statusOut(statusOut));
  radio_node node_u (.clock(clock), .resetn(resetn), .clear(txValid),
    .cca(cca), .lost(lost), .lat(lat), .radioValid(radioValid),
    .radioReq(radioReq), .radioDone(radioDone), .radioRes(radioRes));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task chk(string what, logic [15:0] exp, logic [15:0] got);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task stop_test;
    if (nMismatch == 0 && cmpCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task send(logic [1:0] m, logic [7:0] rr, logic b, logic c, logic [7:0] l,
            logic [7:0] id);
    logic hdr, ack, app;
    int per, all, i;
    note_t n;
    hdr = m == 2'h0 || m == 2'h3;
    ack = (m == 2'h0 || m == 2'h2) && !b;
    app = hdr && rr != 8'h00 && !b;
    per = ack ? 4 : 1;
    all = app ? int'(rr) + 1 : 1;
    n.req = {ack, hdr, hdr, b, id};
    n.stat = {id, 8'h00};
    n.tries = int'(l) + 1;
    if (c) begin
      n.stat[7:0] = 8'h02;
      n.tries = 4 * all;
    end else if (!ack && !app)
      n.tries = 1;
    else if (l >= per * all) begin
      n.stat[7:0] = app ? 8'h21 : 8'h01;
      n.tries = per * all;
    end
    q.push_back(n);
    @(posedge clock);
    txValid <= 1'b1;
    txBcast <= b;
    txFrameId <= id;
    cca <= c;
    lost <= l;
    do @(negedge clock); while (!txReady);
    @(posedge clock);
    txValid <= 1'b0;
    for (i = 0; i < 500 && q.size() > 0; i++) @(posedge clock);
    if (q.size() > 0) begin
      nMismatch++;
      stop_test;
    end
  endtask
  task cfg(logic [1:0] m, logic [7:0] rr);
    @(posedge clock);
    cfgWrite <= 1'b1;
    cfgMode <= m;
    cfgRetry <= rr;
    @(posedge clock);
    cfgWrite <= 1'b0;
    @(negedge clock);
    chk("mode", {14'h0, m}, {14'h0, macModeSetting});
    chk("retry", {8'h0, rr}, {8'h0, appRetryCount});
  endtask
  // Outputs are read at the falling edge, well clear of updates
  always @(negedge clock) begin
    if (radioValid) begin
      tries++;
      chk("radioReq", 16'(q[0].req), 16'(radioReq));
    end
    if (txReady && !prevRdy && q.size() > 0) begin
      chk("statusValid", 16'(q[0].stat[15:8] != 8'h00),
          16'(statusValid));
      if (q[0].stat[15:8] != 8'h00)
        chk("statusOut", q[0].stat, statusOut);
      chk("attempts", q[0].tries[15:0],
          tries[15:0]);
      void'(q.pop_front());
      tries = 0;
    end
    prevRdy = txReady;
  end
  initial begin
    logic [1:0] m;
    logic [7:0] rr;
    m = 2'h0;
    rr = 8'h00;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    chk("modeRst", 16'h0, {14'h0, macModeSetting});
    chk("retryRst", 16'h0, {8'h0, appRetryCount});
    // First frame runs on the reset mode
    for (int i = 0; i < 200; i++) begin
      seed = xs(seed);
      if (i > 0 && seed[3:0] < 4'h6) begin
        m = seed[5:4];
        rr = {6'h0, seed[7:6]};
        cfg(m, rr);
      end
      lat <= seed[9:8];
      send(m, rr, seed[10], seed[13:11] == 3'h0, {4'h0, seed[17:14]},
           seed[20:18] == 3'h0 ? 8'h00 : seed[31:24]);
    end
    stop_test;
  end
  initial begin
    #1000000;
    nMismatch++;
    stop_test;
  end
endmodule // unicast_retry_status_control_tb_top
